// *** rtl/srxls_consts.vh ***
// Purpose: constants for the serial receive lane status block
// Assumes: one clock, synchronous active-low reset
// Notes: lane state codes shared by the controller and the top
// Functional notes
// - parser off, lane 3 parallel data output, width equals gear (8 or 16).
// - capture valid rises at sync byte, holds until stop state; equals sync flag.
// - soft build ends capture on stop of any lane; hardened build lane 0 only.
// - with deskew detection on, flag skew calibration burst, bypass or not.
// - with deskew detection on and no bypass, flag calibration done.
// - clock lane termination on at LP-11 to LP-01, off at LP-11 after HS.
// - each data lane has own termination enable, same on/off conditions.
// - drive lane 0 high-speed enable; hardened build uses it for all lanes.
// - output lane 0 contention indicator.
// - output clock lane contention indicator.
// - clock lane state code: 00 idle, 01 LP-11, 10 LP-01, 11 high-speed.
// - data lane 0 state code on separate output, same codes.
// - data lane count 1 to 4; low-power buses and terminations sized to it.
// - width N is lanes times gear, plus 64 or 32 when parser on.
// - byte clock is ref_clk divided by 4 or 8, running only while data lane 0 is in HS.
`ifndef SRXLS_CONSTS_VH
`define SRXLS_CONSTS_VH
`define SRXLS_ST_IDLE 2'h0
`define SRXLS_ST_LP11 2'h1
`define SRXLS_ST_LP01 2'h2
`define SRXLS_ST_HS 2'h3
`define SRXLS_SYNC_BYTE 8'hb8
`define SRXLS_DIV4 4
`define SRXLS_DIV8 8
`define SRXLS_WIDE_PRODUCT 64
`define SRXLS_WIDE_EXTRA 64
`define SRXLS_NARROW_EXTRA 32
`endif

// *** rtl/srxls_lane_ctrl.v ***
// Purpose: low-power state tracker for one lane
// Assumes: lpP/lpN are synchronous to refClk
// Notes: termination follows the LP-01 entry and the stop after HS
`timescale 1ns/1ns
`include "srxls_consts.vh"
module srxls_lane_ctrl
(
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // lane levels and high-speed start
  input wire lpP,
  input wire lpN,
  input wire hsStart,
  // status
  output reg [1:0] stateCode_r,
  output reg termEn_r
);
  reg [1:0] stateCode_nxt;
  wire stop = lpP & lpN;
  wire lp01 = ~lpP & lpN;
  // =========================================
  // state stepping
  always @*
  begin
    stateCode_nxt = stateCode_r;
    case (stateCode_r)
      `SRXLS_ST_IDLE: if (stop) stateCode_nxt = `SRXLS_ST_LP11;
      `SRXLS_ST_LP11: if (lp01) stateCode_nxt = `SRXLS_ST_LP01;
      `SRXLS_ST_LP01:
      begin
        if (stop)
          stateCode_nxt = `SRXLS_ST_LP11;
        else if (hsStart || (~lpP & ~lpN))
          stateCode_nxt = `SRXLS_ST_HS;
      end
      `SRXLS_ST_HS: if (stop) stateCode_nxt = `SRXLS_ST_LP11;
      default: stateCode_nxt = `SRXLS_ST_IDLE;
    endcase
  end
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      stateCode_r <= `SRXLS_ST_IDLE;
      termEn_r <= 1'b0;
    end
    else
    begin
      stateCode_r <= stateCode_nxt;
      // on at LP-11 to LP-01, off at stop after high speed
      if (stateCode_r == `SRXLS_ST_LP11 && lp01)
        termEn_r <= 1'b1;
      else if (stateCode_r == `SRXLS_ST_HS && stop)
        termEn_r <= 1'b0;
    end
  end
endmodule // srxls_lane_ctrl

// *** rtl/srxls_top.v ***
// Purpose: output and status side of a multi-lane serial receiver
// Assumes: all inputs synchronous to ref_clk; byte data arrives on byteValid
// Notes: byte clock is emitted as a divided enable level, not a real clock
`timescale 1ns/1ns
`include "srxls_consts.vh"
module srxls_top
#(
  parameter NUM_LANES = 4,
  parameter RX_GEAR = 8,
  parameter PARSER_ON = 0,
  parameter HARD_PHY = 1,
  parameter LANE_CTRL_BYPASS = 1,
  parameter DESKEW_EN = 0,
  parameter MISC_STATUS_EN = 1,
  parameter BYTE_DIV = 8,
  parameter AGG_W = (PARSER_ON == 0) ? NUM_LANES * RX_GEAR :
    ((NUM_LANES * RX_GEAR == `SRXLS_WIDE_PRODUCT) ?
    NUM_LANES * RX_GEAR + `SRXLS_WIDE_EXTRA : NUM_LANES * RX_GEAR + `SRXLS_NARROW_EXTRA)
)
(
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // low-power line levels
  input wire clkLpP,
  input wire clkLpN,
  input wire [NUM_LANES-1:0] dataLpP,
  input wire [NUM_LANES-1:0] dataLpN,
  // received high-speed data
  input wire byteValid,
  input wire [AGG_W-1:0] aggData,
  // contention inputs from the line receivers
  input wire lane0ContentionIn,
  input wire clockLaneContentionIn,
  // skew calibration events
  input wire skewBurstSeen,
  input wire skewCalComplete,
  // data outputs
  output reg [RX_GEAR-1:0] lane3_parallel_data,
  output reg [AGG_W-1:0] aggDataOut,
  output wire capture_valid,
  output reg sync_detected,
  output reg byteClk,
  // skew calibration
  output reg skewCalDetected,
  output reg skewCalDone,
  // miscellaneous status
  output wire termClkEn,
  output wire [NUM_LANES-1:0] termDataEn,
  output wire lane0_high_speed_enable,
  output wire [NUM_LANES-1:0] laneHsEnable,
  output wire lane0_contention_flag,
  output wire clock_lane_contention_flag,
  output wire [1:0] clock_lane_state_code,
  output wire [1:0] data_lane0_state_code
);
  wire [1:0] clkCode;
  wire clkTerm;
  wire [2*NUM_LANES-1:0] laneCodes;
  wire [NUM_LANES-1:0] laneTerm;
  // half of the divide ratio, compared at full width so no bits are dropped
  localparam integer HALF_DIV = BYTE_DIV / 2;
  reg [3:0] divCnt_r;
  reg lane0Cont_r;
  reg clkCont_r;
  wire [RX_GEAR-1:0] lane3Slice;
  wire anyStop;
  wire lane0Stop;
  wire endStop;
  wire syncSeen;
  wire laneHs;
  // =========================================
  // lane controllers
  srxls_lane_ctrl uClk
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .lpP(clkLpP),
    .lpN(clkLpN),
    .hsStart(1'b0),
    .stateCode_r(clkCode),
    .termEn_r(clkTerm)
  );
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g = g + 1)
    begin : gLane
      // lane bus sized by lane count
      srxls_lane_ctrl uData
      (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .lpP(dataLpP[g]),
        .lpN(dataLpN[g]),
        .hsStart(byteValid),
        .stateCode_r(laneCodes[2*g+1:2*g]),
        .termEn_r(laneTerm[g])
      );
    end
  endgenerate
  // =========================================
  // capture window
  assign anyStop = |(dataLpP & dataLpN);
  assign lane0Stop = dataLpP[0] & dataLpN[0];
  // soft build watches every lane, hardened build only lane 0
  assign endStop = (HARD_PHY != 0) ? lane0Stop : anyStop;
  assign syncSeen = byteValid && (aggData[7:0] == `SRXLS_SYNC_BYTE);
  // lane 3 slice; lanes beyond the count read as zero
  generate
    if (NUM_LANES > 3 && PARSER_ON == 0)
    begin : gL3
      assign lane3Slice = aggData[4*RX_GEAR-1:3*RX_GEAR];
    end
    else
    begin : gNoL3
      assign lane3Slice = {RX_GEAR{1'b0}};
    end
  endgenerate
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sync_detected <= 1'b0;
      lane3_parallel_data <= {RX_GEAR{1'b0}};
      aggDataOut <= {AGG_W{1'b0}};
    end
    else
    begin
      if (endStop)
        sync_detected <= 1'b0;
      else if (syncSeen)
        sync_detected <= 1'b1;
      if (byteValid)
      begin
        lane3_parallel_data <= lane3Slice;
        aggDataOut <= aggData;
      end
    end
  end
  // same flag seen as a data qualifier
  assign capture_valid = sync_detected;
  // =========================================
  // byte clock: divided, only in high speed
  assign laneHs = (laneCodes[1:0] == `SRXLS_ST_HS);
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      divCnt_r <= 4'h0;
      byteClk <= 1'b0;
    end
    else if (!laneHs)
    begin
      divCnt_r <= 4'h0;
      byteClk <= 1'b0;
    end
    else
    begin
      // toggle every half period of the divide ratio
      if ({28'h0, divCnt_r} == HALF_DIV - 1)
      begin
        divCnt_r <= 4'h0;
        byteClk <= ~byteClk;
      end
      else
        divCnt_r <= divCnt_r + 4'h1;
    end
  end
  // =========================================
  // skew calibration
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      skewCalDetected <= 1'b0;
      skewCalDone <= 1'b0;
    end
    else
    begin
      if (DESKEW_EN != 0 && skewBurstSeen)
        skewCalDetected <= 1'b1;
      else if (endStop)
        skewCalDetected <= 1'b0;
      // done is only reported with deskew detection on and the lane control bypass off
      if (DESKEW_EN != 0 && LANE_CTRL_BYPASS == 0 && skewCalComplete)
        skewCalDone <= 1'b1;
      else if (endStop)
        skewCalDone <= 1'b0;
    end
  end
  // =========================================
  // miscellaneous status, tied low when the option is off
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lane0Cont_r <= 1'b0;
      clkCont_r <= 1'b0;
    end
    else
    begin
      lane0Cont_r <= lane0ContentionIn;
      clkCont_r <= clockLaneContentionIn;
    end
  end
  generate
    if (MISC_STATUS_EN != 0)
    begin : gMisc
      assign termClkEn = clkTerm;
      assign termDataEn = laneTerm;
      assign lane0_high_speed_enable = laneHs;
      // hardened build drives all lanes from lane 0
      assign laneHsEnable = (HARD_PHY != 0) ? {NUM_LANES{laneHs}} :
        laneTerm;
      assign lane0_contention_flag = lane0Cont_r;
      assign clock_lane_contention_flag = clkCont_r;
      assign clock_lane_state_code = clkCode;
      assign data_lane0_state_code = laneCodes[1:0];
    end
    else
    begin : gNoMisc
      assign termClkEn = 1'b0;
      assign termDataEn = {NUM_LANES{1'b0}};
      assign lane0_high_speed_enable = 1'b0;
      assign laneHsEnable = {NUM_LANES{1'b0}};
      assign lane0_contention_flag = 1'b0;
      assign clock_lane_contention_flag = 1'b0;
      assign clock_lane_state_code = `SRXLS_ST_IDLE;
      assign data_lane0_state_code = `SRXLS_ST_IDLE;
    end
  endgenerate
endmodule // srxls_top

// *** tb/srxls_properties.sv ***
// Purpose: checker for the lane status outputs
// Assumes: hardened build, lane 0 alone ends capture
// Notes: bound to srxls_top below
`timescale 1ns/1ns
module srxls_properties
#(
  parameter NUM_LANES = 4
)
(
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // lane levels and contention inputs
  input wire clkLpP,
  input wire clkLpN,
  input wire [NUM_LANES-1:0] dataLpP,
  input wire [NUM_LANES-1:0] dataLpN,
  input wire lane0ContentionIn,
  input wire clockLaneContentionIn,
  // watched outputs
  input wire capture_valid,
  input wire sync_detected,
  input wire termClkEn,
  input wire lane0_high_speed_enable,
  input wire lane0_contention_flag,
  input wire clock_lane_contention_flag,
  input wire [1:0] clock_lane_state_code,
  input wire [1:0] data_lane0_state_code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // assertions
  cap_eq_sync_a: assert property (capture_valid == sync_detected)
    else $error("capture valid differs from sync");
  hs_enable_a: assert property (lane0_high_speed_enable == (data_lane0_state_code == 2'h3))
    else $error("hs enable off state");
  lane0_cont_a: assert property ($past(rst_n) |-> lane0_contention_flag == $past(lane0ContentionIn))
    else $error("lane 0 contention flag wrong");
  clk_cont_a: assert property ($past(rst_n) |-> clock_lane_contention_flag == $past(clockLaneContentionIn))
    else $error("clock contention flag wrong");
  lp01_entry_a: assert property (data_lane0_state_code == 2'h1 && !dataLpP[0] && dataLpN[0] |=> data_lane0_state_code == 2'h2)
    else $error("lane 0 missed lp01");
  clk_hs_a: assert property (clock_lane_state_code == 2'h2 && !clkLpP && !clkLpN |=> clock_lane_state_code == 2'h3)
    else $error("clock lane missed hs");
  term_rise_a: assert property ($rose(termClkEn) |-> clock_lane_state_code == 2'h2)
    else $error("clock termination rose off lp01");
  sync_end_a: assert property (sync_detected && dataLpP[0] && dataLpN[0] |=> !sync_detected)
    else $error("sync held past stop");
  cover property (sync_detected && lane0_high_speed_enable);
  cover property ($fell(sync_detected));
  cover property ($rose(termClkEn));
endmodule // srxls_properties

bind srxls_top srxls_properties #(.NUM_LANES(NUM_LANES)) srxls_properties_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .clkLpP(clkLpP), .clkLpN(clkLpN), .dataLpP(dataLpP),
  .dataLpN(dataLpN), .lane0ContentionIn(lane0ContentionIn),
  .clockLaneContentionIn(clockLaneContentionIn), .capture_valid(capture_valid),
  .sync_detected(sync_detected), .termClkEn(termClkEn),
  .lane0_high_speed_enable(lane0_high_speed_enable), .lane0_contention_flag(lane0_contention_flag),
  .clock_lane_contention_flag(clock_lane_contention_flag),
  .clock_lane_state_code(clock_lane_state_code), .data_lane0_state_code(data_lane0_state_code));

// *** tb/srxls_tx_model.sv ***
// Purpose: transmitter model for four lanes at gear 8
// Assumes: levels change just after a ref_clk rising edge
// Notes: idle word lines carry the inverse of the last word, never a stale copy
`timescale 1ns/1ns
module srxls_tx_model
(
  // clock
  input wire ref_clk,
  // lane levels and words
  output reg clkLpP,
  output reg clkLpN,
  output reg [3:0] dataLpP,
  output reg [3:0] dataLpN,
  output reg byteValid,
  output reg [31:0] aggData
);
  initial
  begin
    {clkLpP, clkLpN, dataLpP, dataLpN, byteValid, aggData} = 0;
  end
  task lp(input [1:0] ck, input [3:0] p, input [3:0] n);
  begin
    @(posedge ref_clk);
    {clkLpP, clkLpN} <= ck;
    dataLpP <= p;
    dataLpN <= n;
  end
  endtask
  task word(input [31:0] w);
  begin
    @(posedge ref_clk);
    byteValid <= 1'h1;
    aggData <= w;
    @(posedge ref_clk);
    byteValid <= 1'h0;
    aggData <= ~w;
  end
  endtask
endmodule // srxls_tx_model

// *** tb/tb.sv ***
// Purpose: walks the lanes through a frame and checks the status outputs
// Assumes: hardened build, deskew detection on, no bypass
// Notes: byte clock ratio 8
`timescale 1ns/1ns
`define CHK(g, e) begin checked = checked + 1; if ((g) !== (e)) begin failCount = failCount + 1; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb;
  reg refClk, rstN, l0Cont, clkCont, skewBurst, skewCmp, prev;
  reg [4:0] n;
  integer checked = 0, failCount = 0;
  wire clkP, clkN, bValid, capValid, syncDet, byteClk, skewDet, skewDone, termClk, hsEn;
  wire cont0, contClk;
  wire [3:0] dP, dN, termData, laneHs;
  wire [31:0] agg, aggOut;
  wire [7:0] lane3Data;
  wire [1:0] clkCode, d0Code;
  always #25 refClk = ~refClk;
  srxls_tx_model srxls_tx_model_inst (.ref_clk(refClk), .clkLpP(clkP), .clkLpN(clkN),
    .dataLpP(dP), .dataLpN(dN), .byteValid(bValid), .aggData(agg));
  srxls_top #(.LANE_CTRL_BYPASS(0), .DESKEW_EN(1)) srxls_top_inst (.ref_clk(refClk),
    .rst_n(rstN), .clkLpP(clkP), .clkLpN(clkN), .dataLpP(dP), .dataLpN(dN), .byteValid(bValid),
    .aggData(agg), .lane0ContentionIn(l0Cont), .clockLaneContentionIn(clkCont),
    .skewBurstSeen(skewBurst), .skewCalComplete(skewCmp), .lane3_parallel_data(lane3Data),
    .aggDataOut(aggOut), .capture_valid(capValid), .sync_detected(syncDet), .byteClk(byteClk),
    .skewCalDetected(skewDet), .skewCalDone(skewDone), .termClkEn(termClk),
    .termDataEn(termData), .lane0_high_speed_enable(hsEn), .laneHsEnable(laneHs),
    .lane0_contention_flag(cont0), .clock_lane_contention_flag(contClk),
    .clock_lane_state_code(clkCode), .data_lane0_state_code(d0Code));
  task wt(input integer k);
  begin
    repeat (k) @(posedge refClk);
    #1;
  end
  endtask
  task stop_test;
  begin
    $display("comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // ==========================================
  // watchdog: the walk needs about 60 cycles
  initial
  begin
    repeat (1000) @(posedge refClk);
    failCount = failCount + 1;
    stop_test;
  end
  // ==========================================
  // frame walk
  initial
  begin
    {refClk, rstN, l0Cont, clkCont, skewBurst, skewCmp} = 0;
    repeat (20) @(posedge refClk);
    rstN <= 1'h1;
    wt(1);
    `CHK(d0Code, 2'h0)
    srxls_tx_model_inst.lp(2'h3, 4'hf, 4'hf);
    wt(2);
    `CHK({clkCode, d0Code}, 4'h5)
    srxls_tx_model_inst.lp(2'h1, 4'h0, 4'hf);
    wt(2);
    `CHK({clkCode, d0Code, hsEn}, 5'h14)
    `CHK({termClk, termData}, 5'h1f)
    srxls_tx_model_inst.lp(2'h0, 4'h0, 4'h0);
    wt(2);
    `CHK({clkCode, d0Code, hsEn, laneHs}, 9'h1ff)
    srxls_tx_model_inst.word(32'ha5c311b8);
    wt(1);
    `CHK({syncDet, capValid, lane3Data}, 10'h3a5)
    `CHK(aggOut, 32'ha5c311b8)
    @(posedge refClk);
    {skewBurst, skewCmp, l0Cont, clkCont} <= 4'hf;
    wt(2);
    `CHK({skewDet, skewDone, cont0, contClk}, 4'hf)
    n = 0;
    prev = byteClk;
    repeat (16)
    begin
      wt(1);
      if (byteClk !== prev)
        n = n + 1;
      prev = byteClk;
    end
    `CHK(n, 5'h4)
    srxls_tx_model_inst.lp(2'h0, 4'h2, 4'h2);
    wt(2);
    `CHK(syncDet, 1'h1)
    srxls_tx_model_inst.lp(2'h3, 4'hf, 4'hf);
    wt(2);
    `CHK({syncDet, d0Code, termClk, termData, byteClk}, 9'h40)
    stop_test;
  end
endmodule // tb
